// ===== hw/srap_pkg.sv
`default_nettype none
package srap_pkg;

   // ------------------------------------------------------------
   // address space
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W       = 10;
   localparam int unsigned SHORT_ADDR_W = 6;
   localparam logic [9:0]  ADDR_FIRST   = 10'h000;
   localparam logic [9:0]  ADDR_LAST    = 10'h3FF;
   localparam logic [9:0]  SHORT_LAST   = 10'h03F;

   // frame buffer window placement
   localparam logic [9:0]  FRAME_BUF_FIRST = 10'h300;
   localparam logic [9:0]  FRAME_BUF_LAST  = 10'h37F;

   // locally held registers
   localparam logic [9:0]  OFF_INT_FLAGS_4 = 10'h007;
   localparam logic [9:0]  OFF_INT_EN_1    = 10'h008;
   localparam logic [7:0]  RST_INT_FLAGS_4 = 8'h00;
   localparam logic [7:0]  RST_INT_EN_1    = 8'h00;

   // ------------------------------------------------------------
   // command byte layout
   // ------------------------------------------------------------
   localparam int unsigned CMD_LONG_BIT  = 7;
   localparam int unsigned CMD_READ_BIT  = 6;
   localparam int unsigned CMD_ADDR_MSB  = 5;
   localparam int unsigned LONG_AUTO_BIT = 3;

   // ------------------------------------------------------------
   // operation status layout
   // ------------------------------------------------------------
   localparam int unsigned OPST_RSVD_BIT = 7;
   localparam int unsigned OPST_MAC_LSB  = 3;
   localparam logic [7:0]  RST_RD_BYTE   = 8'h00;

   // last bit index of a serial byte, cycles of cs synchroniser
   localparam logic [2:0]  BIT_LAST = 3'h7;
   localparam int unsigned SYNC_STAGES = 2;

   // mac activity codes, upper three bits of the four-bit field
   typedef enum logic [2:0] {
      MAC_IDLE          = 3'h0,
      MAC_BACKOFF_WAIT  = 3'h1,
      MAC_CCA           = 3'h2,
      MAC_TX_FRAME      = 3'h3,
      MAC_ACK_AWAITING  = 3'h4,
      MAC_LISTENING     = 3'h5,
      MAC_FRAME_RECEIVING = 3'h6,
      MAC_ACK_TRANSMITTING = 3'h7
   } srap_mac_code_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR2,
      ST_DATA
   } srap_state_t;

endpackage
`default_nettype wire

// ===== hw/srap_sync.sv
`default_nettype none
module srap_sync
#(
   parameter int unsigned W = 1
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] din_i,
   output logic      [W-1:0] dout_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   // two stages; first stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_r <= '0;
         hold_r <= '0;
      end
      else
      begin
         meta_r <= din_i;
         hold_r <= meta_r;
      end
   end

   assign dout_o = hold_r;

endmodule
`default_nettype wire

// ===== hw/srap_top.sv
`default_nettype none
module srap_top
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       spi_sck_i,
   input  wire logic       spi_cs_n_i,
   input  wire logic       spi_sdi_i,
   output logic            spi_sdo_o,
   output logic            spi_sdo_oe_o,
   input  wire logic [3:0] mac_activity_code_i,
   input  wire logic [7:0] int4_event_i,
   output logic      [7:0] interrupt_enables_1_o,
   output logic      [9:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_we_o,
   output logic            reg_re_o,
   input  wire logic [7:0] reg_rdata_i,
   output logic            transmit_start_o,
   output logic            buffer_full_clr_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic in_frame_buf(input logic [9:0] a);
      in_frame_buf = (a >= srap_pkg::FRAME_BUF_FIRST) &&
                     (a <= srap_pkg::FRAME_BUF_LAST);
   endfunction

   function automatic logic is_local(input logic [9:0] a);
      is_local = (a == srap_pkg::OFF_INT_FLAGS_4) ||
                 (a == srap_pkg::OFF_INT_EN_1);
   endfunction

   // ------------------------------------------------------------
   // link domain (serial clock)
   // ------------------------------------------------------------
   logic       sck_rst;
   logic [2:0] bit_cnt_r;
   logic [6:0] rx_sh_r;
   logic [7:0] rx_byte_r;
   logic       rx_tgl_r;
   logic       tx_bit_r;
   logic [7:0] rd_byte_r;

   // cs high holds the bit engine idle; clock idles low between frames
   assign sck_rst = rst_i | spi_cs_n_i;

   // bit counter and input shifter on rising edge
   always_ff @(posedge spi_sck_i or posedge sck_rst)
   begin
      if (sck_rst)
         {bit_cnt_r, rx_sh_r} <= 10'h000;
      else
         {bit_cnt_r, rx_sh_r} <= {3'(bit_cnt_r + 3'h1), rx_sh_r[5:0],
                                  spi_sdi_i};
   end

   // byte and toggle kept across frames: no false toggle at cs release
   always_ff @(posedge spi_sck_i or posedge rst_i)
   begin
      if (rst_i)
         {rx_byte_r, rx_tgl_r} <= 9'h000;
      else if (!spi_cs_n_i && bit_cnt_r == srap_pkg::BIT_LAST)
         {rx_byte_r, rx_tgl_r} <= {rx_sh_r, spi_sdi_i, ~rx_tgl_r};
   end

   // bits 6..0 on falling edge; core holds rd_byte_r still per byte
   always_ff @(negedge spi_sck_i or posedge sck_rst)
   begin
      if (sck_rst)
         tx_bit_r <= 1'b0;
      else
         tx_bit_r <= rd_byte_r[3'h7 - bit_cnt_r];
   end

   // msb of each byte must be valid before its first rising edge
   assign spi_sdo_o    = (bit_cnt_r == 3'h0) ? rd_byte_r[7] : tx_bit_r;
   assign spi_sdo_oe_o = ~spi_cs_n_i;

   // ------------------------------------------------------------
   // crossing into the core domain
   // ------------------------------------------------------------
   logic [1:0] sync_out;
   logic       cs_act_d_r;
   logic       rx_tgl_d_r;
   logic       cs_act;
   logic       cs_fall_p;
   logic       cs_rise_p;
   logic       byte_p;

   srap_sync #(.W(2)) u_sync
   (
      .clk_i  (core_clk_i),
      .rst_i  (rst_i),
      .din_i  ({~spi_cs_n_i, rx_tgl_r}),
      .dout_o (sync_out)
   );

   // edge memory for synchronised levels
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         {cs_act_d_r, rx_tgl_d_r} <= 2'h0;
      else
         {cs_act_d_r, rx_tgl_d_r} <= sync_out;
   end

   assign cs_act    = sync_out[1];
   assign cs_fall_p = cs_act & ~cs_act_d_r;
   assign cs_rise_p = ~cs_act & cs_act_d_r;
   // rx_byte_r is stable for most of a byte after its toggle
   assign byte_p    = cs_act & (sync_out[0] ^ rx_tgl_d_r);

   // ------------------------------------------------------------
   // frame decoder
   // ------------------------------------------------------------
   srap_pkg::srap_state_t state_r;
   logic [9:0] addr_r;
   logic       read_r;
   logic       long_r;
   logic       auto_r;
   logic       buf_hit_r;
   logic       pf_r;
   logic       load_addr;
   logic       data_p;
   logic [9:0] next_addr;

   assign load_addr = byte_p && (state_r == srap_pkg::ST_ADDR2 ||
      (state_r == srap_pkg::ST_CMD && !rx_byte_r[srap_pkg::CMD_LONG_BIT]));
   assign data_p    = byte_p && state_r == srap_pkg::ST_DATA;

   // end of map rolls over; software owns the consequences
   assign next_addr = (addr_r == srap_pkg::ADDR_LAST) ?
                      srap_pkg::ADDR_FIRST : addr_r + 10'h001;

   // frame state; cs release wins over any pending byte
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_r <= srap_pkg::ST_IDLE;
      else if (cs_rise_p || !cs_act)
         state_r <= srap_pkg::ST_IDLE;
      else if (cs_fall_p)
         state_r <= srap_pkg::ST_CMD;
      else if (byte_p)
      begin
         case (state_r)
            srap_pkg::ST_CMD:
               if (rx_byte_r[srap_pkg::CMD_LONG_BIT])
                  state_r <= srap_pkg::ST_ADDR2;
               else
                  state_r <= srap_pkg::ST_DATA;
            srap_pkg::ST_ADDR2: state_r <= srap_pkg::ST_DATA;
            default:            state_r <= state_r;
         endcase
      end
   end

   // command fields
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         {read_r, long_r, auto_r} <= 3'h0;
      else if (cs_fall_p)
         {read_r, long_r, auto_r} <= 3'h0;
      else if (byte_p && state_r == srap_pkg::ST_CMD)
         {read_r, long_r} <= {rx_byte_r[srap_pkg::CMD_READ_BIT],
                              rx_byte_r[srap_pkg::CMD_LONG_BIT]};
      else if (byte_p && state_r == srap_pkg::ST_ADDR2)
         auto_r <= rx_byte_r[srap_pkg::LONG_AUTO_BIT];
   end

   // access address: load, then step after each data byte
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         addr_r <= srap_pkg::ADDR_FIRST;
      else if (byte_p && state_r == srap_pkg::ST_CMD &&
               rx_byte_r[srap_pkg::CMD_LONG_BIT])
         addr_r <= {rx_byte_r[srap_pkg::CMD_ADDR_MSB:0], 4'h0};
      else if (byte_p && state_r == srap_pkg::ST_CMD)
         addr_r <= {4'h0, rx_byte_r[srap_pkg::CMD_ADDR_MSB:0]};
      else if (byte_p && state_r == srap_pkg::ST_ADDR2)
         addr_r <= {addr_r[9:4], rx_byte_r[7:4]};
      else if (data_p)
         addr_r <= next_addr;
   end

   // read prefetch in the same cycle the loaded or stepped address appears
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         pf_r <= 1'b0;
      else
         pf_r <= load_addr | data_p;
   end

   // ------------------------------------------------------------
   // register access
   // ------------------------------------------------------------
   logic       local_rd;
   logic       any_rd;
   logic [7:0] int_flags_4_r;
   logic [7:0] int_en_1_r;
   logic [7:0] op_status;
   logic [7:0] local_data;

   assign any_rd      = pf_r && read_r && state_r == srap_pkg::ST_DATA;
   assign local_rd    = any_rd && is_local(addr_r);
   assign reg_re_o    = any_rd && !is_local(addr_r);
   assign reg_we_o    = data_p && !read_r && !is_local(addr_r);
   assign reg_addr_o  = addr_r;
   assign reg_wdata_o = rx_byte_r;

   // flags set by events, cleared by a read; a new event wins
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         int_flags_4_r <= srap_pkg::RST_INT_FLAGS_4;
      else if (local_rd && addr_r == srap_pkg::OFF_INT_FLAGS_4)
         int_flags_4_r <= int4_event_i;
      else
         int_flags_4_r <= int_flags_4_r | int4_event_i;
   end

   // enables written by software, steer the interrupt sources
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         int_en_1_r <= srap_pkg::RST_INT_EN_1;
      else if (data_p && !read_r && addr_r == srap_pkg::OFF_INT_EN_1)
         int_en_1_r <= rx_byte_r;
   end

   assign interrupt_enables_1_o = int_en_1_r;

   // reserved bit tied low, radio field not carried here
   assign op_status = {1'b0, mac_activity_code_i, 3'h0};
   assign local_data = (addr_r == srap_pkg::OFF_INT_FLAGS_4) ?
                       int_flags_4_r : int_en_1_r;

   // outgoing byte: status at frame start, read data afterwards
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rd_byte_r <= srap_pkg::RST_RD_BYTE;
      else if (cs_fall_p)
         rd_byte_r <= op_status;
      else if (local_rd)
         rd_byte_r <= local_data;
      else if (reg_re_o)
         rd_byte_r <= reg_rdata_i;
   end

   // ------------------------------------------------------------
   // buffer actions at cs release
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         buf_hit_r <= 1'b0;
      else if (cs_fall_p)
         buf_hit_r <= 1'b0;
      else if (data_p && in_frame_buf(addr_r))
         buf_hit_r <= 1'b1;
   end

   // pulses only after release, never mid-burst
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         {transmit_start_o, buffer_full_clr_o} <= 2'h0;
      else
         {transmit_start_o, buffer_full_clr_o} <= {!read_r, read_r} &
            {2{cs_rise_p && long_r && auto_r && buf_hit_r}};
   end

endmodule
`default_nettype wire

// ===== test/srap_host.sv
`default_nettype none
module srap_host
(
   output var logic spi_sck_o,
   output var logic spi_cs_n_o,
   output var logic spi_sdi_o,
   input  wire logic spi_sdo_i
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // host side of the serial port, link clock runs only in frames
   // ------------------------------------------------------------
   initial
   begin
      spi_sck_o  = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_sdi_o  = 1'b1;
   end

   // select, then a quiet gap before the first edge
   task automatic open_frame();
      spi_cs_n_o = 1'b0;
      #100;
   endtask

   // one byte msb first, 15 ns link period, sample on rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         spi_sdi_o = tx[i];
         #7.5 spi_sck_o = 1'b1;
         rx[i] = spi_sdo_i;
         #7.5 spi_sck_o = 1'b0;
      end
      #100;
   endtask

   // release; sdi flips so a stale level is never trusted
   task automatic close_frame();
      spi_cs_n_o = 1'b1;
      spi_sdi_o  = ~spi_sdi_o;
      #100;
   endtask
endmodule
`default_nettype wire

// ===== test/srap_top_chk.sv
`default_nettype none
module srap_top_chk
(
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       spi_cs_n_i,
   input wire logic       spi_sdo_oe_o,
   input wire logic [9:0] reg_addr_o,
   input wire logic       reg_we_o,
   input wire logic       reg_re_o,
   input wire logic       transmit_start_o,
   input wire logic       buffer_full_clr_o,
   input wire logic [7:0] interrupt_enables_1_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // core domain checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_write;
      reg_we_o;
   endsequence
   sequence s_read;
      reg_re_o;
   endsequence
   // one fetch per address load or step, never a held strobe
   property p_re_pulse;
      s_read |=> !reg_re_o;
   endproperty
   property p_oe;
      spi_sdo_oe_o == !spi_cs_n_i;
   endproperty
   property p_step;
      s_write |=> reg_addr_o == $past(reg_addr_o) + 10'h001;
   endproperty
   property p_we_pulse;
      s_write |=> !reg_we_o;
   endproperty
   property p_far;
      (reg_we_o || reg_re_o) |-> reg_addr_o != srap_pkg::OFF_INT_EN_1
         && reg_addr_o != srap_pkg::OFF_INT_FLAGS_4;
   endproperty
   property p_tx_cs;
      transmit_start_o |-> spi_cs_n_i && $past(spi_cs_n_i);
   endproperty
   property p_tx_pulse;
      transmit_start_o |=> !transmit_start_o;
   endproperty
   property p_clr_cs;
      buffer_full_clr_o |-> spi_cs_n_i;
   endproperty
   property p_clr_pulse;
      buffer_full_clr_o |-> !transmit_start_o ##1 !buffer_full_clr_o;
   endproperty
   // local write lands at the addressed cycle or the one after
   property p_en_hold;
      !$stable(interrupt_enables_1_o) |->
         $past(reg_addr_o) == srap_pkg::OFF_INT_EN_1
         || $past(reg_addr_o, 2) == srap_pkg::OFF_INT_EN_1;
   endproperty

   a_oe: assert property (p_oe) else $error("oe not cs");
   a_step: assert property (p_step) else $error("no step");
   a_we_pulse: assert property (p_we_pulse) else $error("we long");
   a_re_pulse: assert property (p_re_pulse) else $error("re long");
   a_far: assert property (p_far) else $error("local strobe");
   a_tx_cs: assert property (p_tx_cs) else $error("tx in frame");
   a_tx_pulse: assert property (p_tx_pulse) else $error("tx long");
   a_clr_cs: assert property (p_clr_cs) else $error("clr in frame");
   a_clr_pulse: assert property (p_clr_pulse) else $error("clr bad");
   a_en_hold: assert property (p_en_hold) else $error("en moved");
endmodule

bind srap_top srap_top_chk chk
(
   .core_clk_i, .rst_i, .spi_cs_n_i, .spi_sdo_oe_o, .reg_addr_o,
   .reg_we_o, .reg_re_o, .transmit_start_o, .buffer_full_clr_o,
   .interrupt_enables_1_o
);
`default_nettype wire

// ===== test/test_spi_register_access_port.sv
`default_nettype none
module test_spi_register_access_port;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic       lng;
      logic [9:0] adr;
      logic [7:0] dat;
      logic [3:0] mac;
   } srap_row_t;

   // ------------------------------------------------------------
   // stimulus, memory behind the register port, checks
   // ------------------------------------------------------------
   logic       core_clk_i = 1'b0;
   logic       rst_i, spi_sck_i, spi_cs_n_i, spi_sdi_i, spi_sdo_o;
   logic       spi_sdo_oe_o, reg_we_o, reg_re_o;
   logic       transmit_start_o, buffer_full_clr_o;
   logic [3:0] mac_activity_code_i;
   logic [7:0] int4_event_i, interrupt_enables_1_o, reg_wdata_o;
   logic [7:0] reg_rdata_i, st, r0, r1;
   logic [7:0] n_tx = 8'h00;
   logic [7:0] n_clr = 8'h00;
   logic [9:0] reg_addr_o;
   logic [7:0] mem [1024];
   int         miscompares = 0;
   int         n_compared = 0;
   int         cyc = 0;
   // wrap row deliberately crosses 0x3ff, expectations follow it
   srap_row_t  rows [8] = '{
      '{1'h0, 10'h008, 8'ha5, 4'h0}, '{1'h0, 10'h03f, 8'h3c, 4'h3},
      '{1'h0, 10'h000, 8'h01, 4'h4}, '{1'h0, 10'h020, 8'hfe, 4'h7},
      '{1'h1, 10'h3ff, 8'h5a, 4'h8}, '{1'h1, 10'h123, 8'h96, 4'hb},
      '{1'h1, 10'h2ff, 8'h0f, 4'hc}, '{1'h1, 10'h040, 8'hf0, 4'hf}};

   srap_top uut (.core_clk_i, .rst_i, .spi_sck_i, .spi_cs_n_i,
      .spi_sdi_i, .spi_sdo_o, .spi_sdo_oe_o, .mac_activity_code_i,
      .int4_event_i, .interrupt_enables_1_o, .reg_addr_o, .reg_wdata_o,
      .reg_we_o, .reg_re_o, .reg_rdata_i, .transmit_start_o,
      .buffer_full_clr_o);
   srap_host host (.spi_sck_o(spi_sck_i), .spi_cs_n_o(spi_cs_n_i),
      .spi_sdi_o(spi_sdi_i), .spi_sdo_i(spi_sdo_o));

   always #4 core_clk_i = ~core_clk_i;

   // memory answers combinationally, as the read strobe demands
   always @(posedge core_clk_i)
   begin
      if (reg_we_o)
         mem[reg_addr_o] <= reg_wdata_o;
      n_tx  <= n_tx + {7'h00, transmit_start_o};
      n_clr <= n_clr + {7'h00, buffer_full_clr_o};
      cyc   <= cyc + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   assign reg_rdata_i = mem[reg_addr_o];

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one frame: command, optional second byte, two data bytes
   task automatic run(input logic rd, input logic lng,
      input logic [9:0] a, input logic auto_f, input logic [7:0] d0);
      logic [7:0] junk;
      host.open_frame();
      host.xfer({lng, rd, lng ? a[9:4] : a[5:0]}, st);
      if (lng)
         host.xfer({a[3:0], auto_f, 3'h0}, junk);
      host.xfer(d0, r0);
      host.xfer(~d0, r1);
      host.close_frame();
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      rst_i = 1'b1;
      mac_activity_code_i = 4'h0;
      int4_event_i = 8'h00;
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      cmp8(interrupt_enables_1_o, srap_pkg::RST_INT_EN_1);
      foreach (rows[i])
      begin
         @(posedge core_clk_i) mac_activity_code_i <= rows[i].mac;
         repeat (2) @(posedge core_clk_i);
         run(1'b0, rows[i].lng, rows[i].adr, 1'b0, rows[i].dat);
         cmp8(st, {1'b0, rows[i].mac, 3'h0});
         cmp8(rows[i].adr == 10'h008 ? interrupt_enables_1_o
            : mem[rows[i].adr], rows[i].dat);
         cmp8(mem[rows[i].adr + 10'h001], ~rows[i].dat);
         run(1'b1, rows[i].lng, rows[i].adr, 1'b0, 8'h00);
         cmp8(r0, rows[i].dat);
         cmp8(r1, ~rows[i].dat);
      end
      // buffer actions: only long, flagged, inside the window
      run(1'b0, 1'b1, 10'h300, 1'b1, 8'h11);
      cmp8(n_tx, 8'h01);
      run(1'b1, 1'b1, 10'h37f, 1'b1, 8'h00);
      cmp8(n_clr, 8'h01);
      run(1'b0, 1'b1, 10'h300, 1'b0, 8'h22);
      run(1'b1, 1'b1, 10'h200, 1'b1, 8'h00);
      cmp8(n_tx, 8'h01);
      cmp8(n_clr, 8'h01);
      // read-clear flags: first read sees events, second sees none
      @(posedge core_clk_i) int4_event_i <= 8'h81;
      @(posedge core_clk_i) int4_event_i <= 8'h00;
      run(1'b1, 1'b0, 10'h007, 1'b0, 8'h00);
      cmp8(r0, 8'h81);
      run(1'b1, 1'b0, 10'h007, 1'b0, 8'h00);
      cmp8(r0, 8'h00);
      // reset in mid-run: enables fall back, the port answers again
      @(posedge core_clk_i) rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      cmp8(interrupt_enables_1_o, srap_pkg::RST_INT_EN_1);
      run(1'b1, 1'b0, 10'h008, 1'b0, 8'h00);
      cmp8(st, {1'b0, mac_activity_code_i, 3'h0});
      cmp8(r0, srap_pkg::RST_INT_EN_1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
